/* File: rtl/tomc_cfg.svh */
// timing and code constants for the transmitter mode controller
`ifndef TOMC_CFG_SVH
`define TOMC_CFG_SVH

`define TOMC_CLK_MHZ 100
`define TOMC_XOSC_WAKE_US 300
`define TOMC_FS_WAKE_US 100
`define TOMC_TX_WAKE_US 50
`define TOMC_XOSC_CYC (`TOMC_XOSC_WAKE_US * `TOMC_CLK_MHZ)
`define TOMC_FS_CYC (`TOMC_FS_WAKE_US * `TOMC_CLK_MHZ)
`define TOMC_TX_CYC (`TOMC_TX_WAKE_US * `TOMC_CLK_MHZ)
`define TOMC_CNT_W 16
`define TOMC_CODE_SLEEP 3'h0
`define TOMC_CODE_STBY 3'h1
`define TOMC_CODE_SYNTH 3'h2
`define TOMC_CODE_TX 3'h3
`define TOMC_REF_DIV 8'h03
`define TOMC_STRAP_ZERO 1'h0
// edges after release before the synchronised strap is trusted
`define TOMC_STRAP_SETTLE 3'h4

`endif

/* File: rtl/tomc_pkg.sv */
// types shared by the transmitter mode controller
package tomc_pkg;
	typedef enum logic [3:0]
	{
		TOMC_SLEEP = 4'h1,
		TOMC_STBY = 4'h2,
		TOMC_SYNTH = 4'h4,
		TOMC_TX = 4'h8
	} tomc_mode_t;

	typedef enum logic [1:0]
	{
		TOMC_APP_HOST = 2'h1,
		TOMC_APP_ALONE = 2'h2
	} tomc_app_t;
endpackage : tomc_pkg

/* File: rtl/tomc_sync.sv */
// three-stage input synchroniser with agreement filter
`include "tomc_cfg.svh"
module tomc_sync
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// pin
	input wire logic din,
	output logic dout
);
	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} tomc_sync_t;
	tomc_sync_t st_r;
	tomc_sync_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3)
		begin
			st_nxt.q = st_r.s3;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.q;
endmodule : tomc_sync

/* File: rtl/tomc_refdiv.sv */
// reference clock divider for the attached controller
`include "tomc_cfg.svh"
module tomc_refdiv
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// control
	input wire logic en,
	output logic clk_out
);
	typedef struct packed
	{
		logic [7:0] cnt;
		logic q;
	} tomc_div_t;
	tomc_div_t st_r;
	tomc_div_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (!en)
		begin
			st_nxt.cnt = 8'h00;
			st_nxt.q = 1'b0;
		end
		else if (st_r.cnt == `TOMC_REF_DIV)
		begin
			st_nxt.cnt = 8'h00;
			st_nxt.q = ~st_r.q;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign clk_out = st_r.q;
endmodule : tomc_refdiv

/* File: rtl/tomc_ctrl.sv */
// operating and application mode controller of the transmitter
// Functional notes
// - sleep: only serial interface powered
// - standby: crystal oscillator on too
// - synth mode: add synthesizer, amplifier off
// - transmit: all blocks on
// - upward steps pass each intermediate mode
// - sleep to transmit takes about 450 us
// - strap sampled only at reset release
// - reset pulse needed to change application mode
// - strap low: device is serial slave
// - stand-alone: master fetching memory configuration
// - button input loads configuration and transmits
// - reference clock output from crystal oscillator
// - strap high: stand-alone, serial master
`include "tomc_cfg.svh"
module tomc_ctrl
	import tomc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// mode field write from the serial register file
	input wire logic mode_wr,
	input wire logic [2:0] mode_wdata,
	// pins
	input wire logic app_mode_strap,
	input wire logic button_in,
	// stand-alone sequencer handshake
	input wire logic cfg_load_done,
	input wire logic payload_done,
	// application mode
	output logic spi_master,
	output logic spi_slave,
	output tomc_app_t app_mode,
	output logic cfg_load_req,
	output logic payload_req,
	// block enables and status
	output logic spi_en,
	output logic xosc_en,
	output logic synth_en,
	output logic power_amplifier_en,
	output tomc_mode_t cur_mode,
	output logic [2:0] mode_rdata,
	output logic seq_busy,
	output logic ref_clock_out
);
	typedef struct packed
	{
		tomc_mode_t cur;
		tomc_mode_t tgt;
		logic [`TOMC_CNT_W-1:0] cnt;
		logic strap_taken;
		logic [2:0] settle;
		tomc_app_t app;
		logic load_req;
		logic pay_req;
		logic boot_done;
		logic btn_d;
		logic spi_en;
		logic xosc_en;
		logic synth_en;
		logic pa_en;
		logic [2:0] rdata;
		logic busy;
	} tomc_ctrl_t;

	tomc_ctrl_t st_r;
	tomc_ctrl_t st_nxt;
	logic strap_s;
	logic btn_s;
	logic ref_q;

	////////////////////////////////////////////////////////////////////////
	tomc_sync u_strap_sync
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.din(app_mode_strap),
		.dout(strap_s)
	);

	tomc_sync u_btn_sync
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.din(button_in),
		.dout(btn_s)
	);

	// reference clock runs whenever the crystal oscillator does
	tomc_refdiv u_refdiv
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.en(st_r.xosc_en),
		.clk_out(ref_q)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic tomc_mode_t decode(input logic [2:0] c, input tomc_mode_t keep);
		tomc_mode_t m;
		m = keep;
		unique case (c)
			`TOMC_CODE_SLEEP: m = TOMC_SLEEP;
			`TOMC_CODE_STBY: m = TOMC_STBY;
			`TOMC_CODE_SYNTH: m = TOMC_SYNTH;
			`TOMC_CODE_TX: m = TOMC_TX;
			default: m = keep;
		endcase
		return m;
	endfunction : decode

	function automatic logic [2:0] encode(input tomc_mode_t m);
		logic [2:0] c;
		c = `TOMC_CODE_SLEEP;
		unique case (m)
			TOMC_SLEEP: c = `TOMC_CODE_SLEEP;
			TOMC_STBY: c = `TOMC_CODE_STBY;
			TOMC_SYNTH: c = `TOMC_CODE_SYNTH;
			TOMC_TX: c = `TOMC_CODE_TX;
		endcase
		return c;
	endfunction : encode

	// dwell in each intermediate mode before stepping up
	function automatic logic [`TOMC_CNT_W-1:0] dwell(input tomc_mode_t m);
		logic [`TOMC_CNT_W-1:0] d;
		d = `TOMC_CNT_W'(`TOMC_XOSC_CYC);
		unique case (m)
			TOMC_SLEEP: d = `TOMC_CNT_W'(`TOMC_XOSC_CYC);
			TOMC_STBY: d = `TOMC_CNT_W'(`TOMC_FS_CYC);
			TOMC_SYNTH: d = `TOMC_CNT_W'(`TOMC_TX_CYC);
			TOMC_TX: d = `TOMC_CNT_W'(`TOMC_TX_CYC);
		endcase
		return d;
	endfunction : dwell

	function automatic tomc_mode_t step_up(input tomc_mode_t m);
		tomc_mode_t n;
		n = m;
		unique case (m)
			TOMC_SLEEP: n = TOMC_STBY;
			TOMC_STBY: n = TOMC_SYNTH;
			TOMC_SYNTH: n = TOMC_TX;
			TOMC_TX: n = TOMC_TX;
		endcase
		return n;
	endfunction : step_up

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_nxt = st_r;
		// the strap synchroniser is cleared by reset, so its output only
		// reflects the pin a few edges after release; latch it once then
		if (!st_r.strap_taken)
		begin
			if (st_r.settle != `TOMC_STRAP_SETTLE)
			begin
				st_nxt.settle = st_r.settle + 3'h1;
			end
			else
			begin
				st_nxt.strap_taken = 1'b1;
				if (strap_s == `TOMC_STRAP_ZERO)
				begin
					st_nxt.app = TOMC_APP_HOST;
				end
				else
				begin
					st_nxt.app = TOMC_APP_ALONE;
					st_nxt.load_req = 1'b1;
				end
			end
		end
		st_nxt.btn_d = btn_s;
		if (st_r.app == TOMC_APP_ALONE)
		begin
			if (st_r.load_req && cfg_load_done)
			begin
				st_nxt.load_req = 1'b0;
				st_nxt.boot_done = 1'b1;
			end
			// button edge while idle reloads and sends its payload
			if (st_r.boot_done && !st_r.pay_req && !st_r.load_req && (btn_s != st_r.btn_d))
			begin
				st_nxt.load_req = 1'b1;
				st_nxt.pay_req = 1'b1;
				st_nxt.tgt = TOMC_TX;
			end
			if (st_r.pay_req && !st_r.load_req && payload_done)
			begin
				st_nxt.pay_req = 1'b0;
				st_nxt.tgt = TOMC_SLEEP;
			end
		end
		else if (mode_wr)
		begin
			st_nxt.tgt = decode(mode_wdata, st_r.tgt);
		end
		// sequencing toward the target mode
		if (st_nxt.tgt == st_r.cur)
		begin
			st_nxt.cnt = '0;
		end
		else if (st_nxt.tgt < st_r.cur)
		begin
			st_nxt.cur = st_nxt.tgt;
			st_nxt.cnt = '0;
		end
		else if (st_r.cnt >= dwell(st_r.cur) - `TOMC_CNT_W'(1))
		begin
			st_nxt.cur = step_up(st_r.cur);
			st_nxt.cnt = '0;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + `TOMC_CNT_W'(1);
		end
		st_nxt.spi_en = 1'b1;
		st_nxt.xosc_en = (st_nxt.cur != TOMC_SLEEP);
		st_nxt.synth_en = (st_nxt.cur == TOMC_SYNTH) || (st_nxt.cur == TOMC_TX);
		st_nxt.pa_en = (st_nxt.cur == TOMC_TX);
		st_nxt.rdata = encode(st_nxt.tgt);
		st_nxt.busy = (st_nxt.tgt != st_nxt.cur);
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r.cur <= TOMC_SLEEP;
			st_r.tgt <= TOMC_SLEEP;
			st_r.cnt <= '0;
			st_r.strap_taken <= 1'b0;
			st_r.settle <= 3'h0;
			st_r.app <= TOMC_APP_HOST;
			st_r.load_req <= 1'b0;
			st_r.pay_req <= 1'b0;
			st_r.boot_done <= 1'b0;
			st_r.btn_d <= 1'b0;
			st_r.spi_en <= 1'b1;
			st_r.xosc_en <= 1'b0;
			st_r.synth_en <= 1'b0;
			st_r.pa_en <= 1'b0;
			st_r.rdata <= `TOMC_CODE_SLEEP;
			st_r.busy <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one-hot application code: each role is a single register bit
	assign spi_master = st_r.app[1];
	assign spi_slave = st_r.app[0];
	assign app_mode = st_r.app;
	assign cfg_load_req = st_r.load_req;
	assign payload_req = st_r.pay_req;
	assign spi_en = st_r.spi_en;
	assign xosc_en = st_r.xosc_en;
	assign synth_en = st_r.synth_en;
	assign power_amplifier_en = st_r.pa_en;
	assign cur_mode = st_r.cur;
	assign mode_rdata = st_r.rdata;
	assign seq_busy = st_r.busy;
	assign ref_clock_out = ref_q;
endmodule : tomc_ctrl

/* File: test/tomc_ctrl_assertions.sv */
// concurrent checks on the transmitter mode controller ports
module tomc_ctrl_assertions
	import tomc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// mode write
	input wire logic mode_wr,
	input wire logic [2:0] mode_wdata,
	// status
	input wire tomc_pkg::tomc_app_t app_mode,
	input wire logic spi_master,
	input wire logic spi_slave,
	input wire logic spi_en,
	input wire logic xosc_en,
	input wire logic synth_en,
	input wire logic power_amplifier_en,
	input wire tomc_pkg::tomc_mode_t cur_mode,
	input wire logic [2:0] mode_rdata
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// cycles since reset release, saturating; the strap latch settles early
	logic [3:0] since_rst_r;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			since_rst_r <= 4'h0;
		end
		else if (since_rst_r != 4'hF)
		begin
			since_rst_r <= since_rst_r + 4'h1;
		end
	end
	AST_SLEEP: assert property (cur_mode == TOMC_SLEEP |-> !xosc_en && !synth_en)
		else $error("sleep enables wrong");
	AST_STBY: assert property (cur_mode == TOMC_STBY |-> xosc_en && !synth_en)
		else $error("standby enables wrong");
	AST_SYNTH: assert property (cur_mode == TOMC_SYNTH |-> synth_en && !power_amplifier_en)
		else $error("synth enables wrong");
	AST_TX: assert property (cur_mode == TOMC_TX |-> xosc_en && power_amplifier_en)
		else $error("transmit enables wrong");
	AST_PA_UP: assert property ($rose(power_amplifier_en) |-> $past(synth_en))
		else $error("amplifier skipped synth step");
	AST_SYN_UP: assert property ($rose(synth_en) |-> $past(xosc_en) && spi_en)
		else $error("synth skipped oscillator step");
	AST_STRAP: assert property (since_rst_r >= 4'h8 |-> $stable(app_mode))
		else $error("application mode changed");
	AST_ROLE: assert property (spi_master == (app_mode == TOMC_APP_ALONE) && spi_slave != spi_master)
		else $error("serial role wrong");
	AST_DOWN: assert property (mode_wr && mode_wdata == 3'h0 && app_mode == TOMC_APP_HOST
		|=> cur_mode == TOMC_SLEEP)
		else $error("sleep not immediate");
	AST_RSVD: assert property (mode_wr && mode_wdata[2] && app_mode == TOMC_APP_HOST
		|=> $stable(mode_rdata))
		else $error("reserved code taken");
endmodule : tomc_ctrl_assertions

bind tomc_ctrl tomc_ctrl_assertions u_chk (.ref_clk(ref_clk), .rst(rst), .mode_wr(mode_wr),
	.mode_wdata(mode_wdata), .app_mode(app_mode), .spi_master(spi_master),
	.spi_slave(spi_slave), .spi_en(spi_en), .xosc_en(xosc_en), .synth_en(synth_en),
	.power_amplifier_en(power_amplifier_en), .cur_mode(cur_mode), .mode_rdata(mode_rdata));

/* File: test/tomc_loader.sv */
// behavioural configuration memory loader answering the stand-alone requests
module tomc_loader
#(
	parameter int DLY = 3
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// requests and answers
	input wire logic cfg_load_req,
	input wire logic payload_req,
	output logic cfg_load_done,
	output logic payload_done
);
	logic [7:0] cnt_r;
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			cnt_r <= 8'h00;
		else
			cnt_r <= (cfg_load_req || payload_req) ? cnt_r + 8'h01 : 8'h00;
	// load finishes before payload, as the device expects
	assign cfg_load_done = cfg_load_req && cnt_r == 8'(DLY);
	assign payload_done = payload_req && !cfg_load_req && cnt_r >= 8'(2 * DLY);
endmodule : tomc_loader

/* File: test/tomc_ctrl_bench.sv */
// self-checking bench of the transmitter mode controller
module tomc_ctrl_bench
	import tomc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rst, mode_wr, app_mode_strap, button_in, cfg_load_done, payload_done;
	logic [2:0] mode_wdata, mode_rdata;
	logic spi_master, spi_slave, cfg_load_req, payload_req, spi_en, xosc_en, synth_en;
	logic power_amplifier_en, seq_busy, ref_clock_out, b;
	tomc_app_t app_mode;
	tomc_mode_t cur_mode;
	int miscompares, n_checks, n;
	logic [7:0] seed;
	tomc_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
		.app_mode_strap(app_mode_strap), .button_in(button_in), .cfg_load_done(cfg_load_done),
		.payload_done(payload_done), .spi_master(spi_master), .spi_slave(spi_slave),
		.app_mode(app_mode), .cfg_load_req(cfg_load_req), .payload_req(payload_req),
		.spi_en(spi_en), .xosc_en(xosc_en), .synth_en(synth_en),
		.power_amplifier_en(power_amplifier_en), .cur_mode(cur_mode), .mode_rdata(mode_rdata),
		.seq_busy(seq_busy), .ref_clock_out(ref_clock_out));
	// the bench host leaves the bit clock unused
	// transmit bits go on the host's own data pin, outside this block
	tomc_loader u_mem (.ref_clk(ref_clk), .rst(rst), .cfg_load_req(cfg_load_req),
		.payload_req(payload_req), .cfg_load_done(cfg_load_done), .payload_done(payload_done));
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_mode(input tomc_mode_t m);
		chk(16'(cur_mode), 16'(m));
		chk({xosc_en, synth_en, power_amplifier_en, spi_en},
			{m != TOMC_SLEEP, m == TOMC_SYNTH || m == TOMC_TX, m == TOMC_TX, 1'h1});
	endtask : chk_mode
	task automatic wr(input logic [2:0] c);
		@(posedge ref_clk);
		mode_wr <= 1'h1;
		mode_wdata <= c;
		@(posedge ref_clk);
		mode_wr <= 1'h0;
		@(posedge ref_clk);
		#1;
	endtask : wr
	// bounded wait; the count is the latency in cycles
	task automatic wait_mode(input tomc_mode_t m);
		n = 0;
		while (cur_mode !== m && n < 50000)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask : wait_mode
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial
	begin
		#700us;
		miscompares++;
		summarize();
	end
	initial
	begin
		{rst, mode_wr, mode_wdata, app_mode_strap, button_in} = 7'h40;
		{miscompares, n_checks, seed} = {32'h0, 32'h0, 8'h20};
		repeat (20) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		#1;
		chk({app_mode, spi_slave}, {TOMC_APP_HOST, 1'h1});
		chk_mode(TOMC_SLEEP);
		@(posedge ref_clk);
		app_mode_strap <= 1'h1;
		wr(3'h3);
		chk({mode_rdata, seq_busy}, 4'h7);
		wait_mode(TOMC_STBY);
		chk(16'(n), 16'h752E);
		chk_mode(TOMC_STBY);
		wait_mode(TOMC_SYNTH);
		chk(16'(n), 16'h2710);
		chk_mode(TOMC_SYNTH);
		wait_mode(TOMC_TX);
		chk(16'(n), 16'h1388);
		chk_mode(TOMC_TX);
		chk({app_mode, seq_busy}, {TOMC_APP_HOST, 1'h0});
		n = 0;
		repeat (16)
		begin
			b = ref_clock_out;
			@(posedge ref_clk);
			#1;
			n += int'(ref_clock_out !== b);
		end
		chk(16'(n), 16'h0004);
		repeat (4)
		begin
			seed = lfsr(seed);
			wr({1'h1, seed[1:0]});
			chk(16'(mode_rdata), 16'h0003);
		end
		for (int i = 2; i >= 0; i--)
		begin
			wr(3'(i));
			chk_mode(tomc_mode_t'(4'h1 << i));
		end
		chk(16'(ref_clock_out), 16'h0000);
		@(posedge ref_clk);
		rst <= 1'h1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'h0;
		repeat (5) @(posedge ref_clk);
		#1;
		chk({app_mode, spi_master, cfg_load_req}, {TOMC_APP_ALONE, 2'h3});
		wr(3'h3);
		chk(16'(mode_rdata), 16'h0000);
		@(posedge ref_clk);
		button_in <= 1'h1;
		for (n = 0; payload_req !== 1'h1 && n < 20; n++)
		begin
			@(posedge ref_clk);
			#1;
		end
		chk({payload_req, mode_rdata}, 4'hB);
		for (n = 0; payload_req !== 1'h0 && n < 50; n++)
		begin
			@(posedge ref_clk);
			#1;
		end
		@(posedge ref_clk);
		#1;
		chk({payload_req, mode_rdata}, 4'h0);
		chk_mode(TOMC_SLEEP);
		summarize();
	end
endmodule : tomc_ctrl_bench
